// File: hw/bfiu_top.sv
// bit and flag instruction unit with avalon-mm register access
`timescale 1ns/1ps
module bfiu_top (
   // clock, reset, enable
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   // avalon-mm slave
   input  wire logic [3:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   // machine control
   output logic             SLEEP_REQ,
   output logic             WATCHDOG_RESTART,
   output logic             DEBUG_BREAK
);
   logic        rd_stb;
   logic        wr_stb;
   logic        wait_c;
   logic [7:0]  operand_q;
   logic [7:0]  status_q;
   logic [7:0]  result_q;
   logic [31:0] rdata_q;
   logic        sleep_q;
   logic        wdr_q;
   logic        brk_q;
   logic [7:0]  alu_res;
   logic [7:0]  alu_stat;

   bfiu_avalon_slave u_slave (
      .clk         (SYS_CLK),
      .rst         (RST),
      .ce          (CE),
      .address     (AVS_ADDRESS),
      .read        (AVS_READ),
      .write       (AVS_WRITE),
      .waitrequest (wait_c),
      .rd_strobe   (rd_stb),
      .wr_strobe   (wr_stb)
   );

   wire logic       sel_operand = (AVS_ADDRESS == bfiu_pkg::ADDR_OPERAND);
   wire logic       sel_status  = (AVS_ADDRESS == bfiu_pkg::ADDR_STATUS);
   wire logic       sel_command = (AVS_ADDRESS == bfiu_pkg::ADDR_COMMAND);
   wire logic       sel_result  = (AVS_ADDRESS == bfiu_pkg::ADDR_RESULT);
   wire logic       exec        = wr_stb & sel_command;
   wire logic [4:0] cmd_op      = AVS_WRITEDATA[4:0];
   wire logic [2:0] cmd_bit     = AVS_WRITEDATA[10:8];

   bfiu_shift_unit u_alu (
      .op         (cmd_op),
      .bit_sel    (cmd_bit),
      .operand    (operand_q),
      .status_in  (status_q),
      .result     (alu_res),
      .status_out (alu_stat)
   );

   wire logic is_sleep = exec & (cmd_op == bfiu_pkg::OP_SLEEP);
   wire logic is_wdr   = exec & (cmd_op == bfiu_pkg::OP_WATCHDOG_RESTART);
   wire logic is_brk   = exec & (cmd_op == bfiu_pkg::OP_BREAK);

   logic [31:0] rdata_d;
   always_comb begin
      if (sel_operand) begin
         rdata_d = {24'h00_0000, operand_q};
      end else if (sel_status) begin
         rdata_d = {24'h00_0000, status_q};
      end else if (sel_result) begin
         rdata_d = {24'h00_0000, result_q};
      end else begin
         // command and unmapped offsets read zero
         rdata_d = 32'h0000_0000;
      end
   end

   // read data registered one cycle ahead: slave holds waitrequest that cycle
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         rdata_q <= 32'h0000_0000;
      end else if (CE) begin
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         operand_q <= bfiu_pkg::DATA_RESET;
         status_q  <= bfiu_pkg::STATUS_RESET;
         result_q  <= bfiu_pkg::DATA_RESET;
      end else if (CE) begin
         if (exec) begin
            // result written back to operand so shifts chain like a register
            operand_q <= alu_res;
            result_q  <= alu_res;
            status_q  <= alu_stat;
         end else if (wr_stb & sel_operand) begin
            operand_q <= AVS_WRITEDATA[7:0];
         end else if (wr_stb & sel_status) begin
            status_q <= AVS_WRITEDATA[7:0];
         end
      end
   end

   // machine-control pulses, one cycle each, no flag change
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         sleep_q <= 1'b0;
         wdr_q   <= 1'b0;
         brk_q   <= 1'b0;
      end else if (CE) begin
         sleep_q <= is_sleep;
         wdr_q   <= is_wdr;
         brk_q   <= is_brk;
      end
   end

   // waitrequest is combinational from the slave's pending flop, the request and the clock enable
   assign AVS_WAITREQUEST  = wait_c;
   assign AVS_READDATA     = rdata_q;
   assign SLEEP_REQ        = sleep_q;
   assign WATCHDOG_RESTART = wdr_q;
   assign DEBUG_BREAK      = brk_q;
endmodule // bfiu_top

// File: hw/bfiu_pkg.sv
// constants for the bit and flag instruction unit
package bfiu_pkg;
   // opcodes presented on the command port
   typedef enum logic [4:0] {
      OP_NOP                 = 5'h00,
      OP_ROTATE_LEFT_CARRY   = 5'h01,
      OP_ROTATE_RIGHT_CARRY  = 5'h02,
      OP_ARITH_SHIFT_RIGHT   = 5'h03,
      OP_NIBBLE_SWAP         = 5'h04,
      OP_BIT_TO_COPY_FLAG    = 5'h05,
      OP_COPY_FLAG_TO_BIT    = 5'h06,
      OP_OVERFLOW_FLAG_SET   = 5'h07,
      OP_OVERFLOW_FLAG_CLEAR = 5'h08,
      OP_SIGN_FLAG_SET       = 5'h09,
      OP_SIGN_FLAG_CLEAR     = 5'h0a,
      OP_HALF_CARRY_CLEAR    = 5'h0b,
      OP_SLEEP               = 5'h0c,
      OP_WATCHDOG_RESTART    = 5'h0d,
      OP_BREAK               = 5'h0e,
      OP_FLAG_SET            = 5'h0f,
      OP_FLAG_CLEAR          = 5'h10
   } bfiu_op_type;

   // status_register bit positions
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_Z = 1;
   localparam int unsigned FLAG_N = 2;
   localparam int unsigned FLAG_V = 3;
   localparam int unsigned FLAG_S = 4;
   localparam int unsigned FLAG_H = 5;
   localparam int unsigned FLAG_T = 6;
   localparam int unsigned FLAG_I = 7;

   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET   = 8'h00;

   // bus offsets (byte addresses, one word each)
   localparam logic [3:0] ADDR_OPERAND = 4'h0;
   localparam logic [3:0] ADDR_STATUS  = 4'h4;
   localparam logic [3:0] ADDR_COMMAND = 4'h8;
   localparam logic [3:0] ADDR_RESULT  = 4'hc;
   localparam logic [3:0] ADDR_EVENTS  = 4'h0;

   localparam int unsigned EXEC_CYCLES = 1;
endpackage

// File: hw/bfiu_shift_unit.sv
// combinational data path of the shift and bit instructions
`timescale 1ns/1ps
module bfiu_shift_unit (
   // command
   input  wire logic [4:0] op,
   input  wire logic [2:0] bit_sel,
   // operands
   input  wire logic [7:0] operand,
   input  wire logic [7:0] status_in,
   // results
   output logic [7:0]      result,
   output logic [7:0]      status_out
);
   wire logic       c_in = status_in[bfiu_pkg::FLAG_C];
   wire logic       t_in = status_in[bfiu_pkg::FLAG_T];
   wire logic [7:0] rol_v = {operand[6:0], c_in};
   wire logic [7:0] ror_v = {c_in, operand[7:1]};
   wire logic [7:0] asr_v = {operand[7], operand[7:1]};
   wire logic [7:0] swp_v = {operand[3:0], operand[7:4]};
   wire logic [7:0] one_hot = 8'h01 << bit_sel;
   wire logic [7:0] bld_v = t_in ? (operand | one_hot) : (operand & ~one_hot);
   wire logic       bst_v = operand[bit_sel];

   logic [7:0] r;
   logic [7:0] s;
   logic       cout;
   logic       shift_op;
   always_comb begin
      r        = operand;
      s        = status_in;
      cout     = 1'b0;
      shift_op = 1'b0;
      case (op)
         bfiu_pkg::OP_ROTATE_LEFT_CARRY: begin
            r = rol_v;
            cout = operand[7];
            shift_op = 1'b1;
         end
         bfiu_pkg::OP_ROTATE_RIGHT_CARRY: begin
            r = ror_v;
            cout = operand[0];
            shift_op = 1'b1;
         end
         bfiu_pkg::OP_ARITH_SHIFT_RIGHT: begin
            r = asr_v;
            cout = operand[0];
            shift_op = 1'b1;
         end
         bfiu_pkg::OP_NIBBLE_SWAP:         r = swp_v;
         bfiu_pkg::OP_BIT_TO_COPY_FLAG:    s[bfiu_pkg::FLAG_T] = bst_v;
         bfiu_pkg::OP_COPY_FLAG_TO_BIT:    r = bld_v;
         bfiu_pkg::OP_OVERFLOW_FLAG_SET:   s[bfiu_pkg::FLAG_V] = 1'b1;
         bfiu_pkg::OP_OVERFLOW_FLAG_CLEAR: s[bfiu_pkg::FLAG_V] = 1'b0;
         bfiu_pkg::OP_SIGN_FLAG_SET:       s[bfiu_pkg::FLAG_S] = 1'b1;
         bfiu_pkg::OP_SIGN_FLAG_CLEAR:     s[bfiu_pkg::FLAG_S] = 1'b0;
         bfiu_pkg::OP_HALF_CARRY_CLEAR:    s[bfiu_pkg::FLAG_H] = 1'b0;
         bfiu_pkg::OP_FLAG_SET:            s[bit_sel] = 1'b1;
         bfiu_pkg::OP_FLAG_CLEAR:          s[bit_sel] = 1'b0;
         default: begin
         end
      endcase
      if (shift_op) begin
         // v = n xor c after the shift, s = n xor v
         s[bfiu_pkg::FLAG_C] = cout;
         s[bfiu_pkg::FLAG_Z] = (r == 8'h00);
         s[bfiu_pkg::FLAG_N] = r[7];
         s[bfiu_pkg::FLAG_V] = r[7] ^ cout;
         s[bfiu_pkg::FLAG_S] = cout;
      end
      result     = r;
      status_out = s;
   end
endmodule // bfiu_shift_unit

// File: hw/bfiu_avalon_slave.sv
// avalon-mm slave: access strobes and waitrequest for the unit's registers; address decode is in bfiu_top
`timescale 1ns/1ps
module bfiu_avalon_slave (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // avalon side
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   output logic             waitrequest,
   output logic             rd_strobe,
   output logic             wr_strobe
);
   // one wait cycle per access; strobes fire on the accepting edge
   // a low enable stretches the wait, else an access would be answered but lost
   logic pend_q;
   logic pend_d;
   wire logic req = read | write;
   assign pend_d      = req & ~pend_q;
   assign waitrequest = req & (~pend_q | ~ce);
   assign rd_strobe   = read & pend_q & ce;
   assign wr_strobe   = write & pend_q & ce;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_q <= 1'b0;
      end else if (ce) begin
         pend_q <= pend_d;
      end
   end
endmodule // bfiu_avalon_slave

// File: verification/bfiu_chk.sv
// port-level assertions for the bit and flag instruction unit
`timescale 1ns/1ps
module bfiu_chk (
   // clock and reset
   input wire logic        SYS_CLK,
   input wire logic        RST,
   input wire logic        CE,
   // avalon-mm
   input wire logic [3:0]  AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   // machine control
   input wire logic        SLEEP_REQ,
   input wire logic        WATCHDOG_RESTART,
   input wire logic        DEBUG_BREAK
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // accepted command write; a frozen clock enable is not covered
   wire       cmd_acc = CE && AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == bfiu_pkg::ADDR_COMMAND;
   wire [4:0] cmd_op  = AVS_WRITEDATA[4:0];
   wire       rd_acc  = AVS_READ && !AVS_WAITREQUEST;
   chk_sleep_cause: assert property (SLEEP_REQ == ($past(CE) ? $past(cmd_acc && cmd_op == bfiu_pkg::OP_SLEEP) : $past(SLEEP_REQ)))
      else $error("sleep request does not follow its command");
   chk_wdr_cause: assert property (WATCHDOG_RESTART == ($past(CE) ? $past(cmd_acc && cmd_op == bfiu_pkg::OP_WATCHDOG_RESTART) : $past(WATCHDOG_RESTART)))
      else $error("watchdog restart does not follow its command");
   chk_break_cause: assert property (DEBUG_BREAK == ($past(CE) ? $past(cmd_acc && cmd_op == bfiu_pkg::OP_BREAK) : $past(DEBUG_BREAK)))
      else $error("debug break does not follow its command");
   chk_pulses_excl: assert property ($onehot0({SLEEP_REQ, WATCHDOG_RESTART, DEBUG_BREAK}))
      else $error("more than one control pulse at once");
   chk_wait_first: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
      else $error("request answered in its first cycle");
   chk_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CE ##1 CE |-> !AVS_WAITREQUEST)
      else $error("request not answered after one cycle");
   chk_freeze_wait: assert property (!CE && (AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
      else $error("request answered while enable low");
   chk_freeze_pulse: assert property (!CE |=> $stable({SLEEP_REQ, WATCHDOG_RESTART, DEBUG_BREAK}))
      else $error("control pulse changed while enable low");
   chk_freeze_read: assert property (!CE |=> $stable(AVS_READDATA))
      else $error("read data changed while enable low");
   chk_read_upper: assert property (rd_acc |-> AVS_READDATA[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
   chk_cmd_zero: assert property (rd_acc && AVS_ADDRESS == bfiu_pkg::ADDR_COMMAND |-> AVS_READDATA == 32'h0000_0000)
      else $error("command register read not zero");
endmodule // bfiu_chk

bind bfiu_top bfiu_chk bfiu_chk_i (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .SLEEP_REQ(SLEEP_REQ), .WATCHDOG_RESTART(WATCHDOG_RESTART),
   .DEBUG_BREAK(DEBUG_BREAK));

// File: verification/bit_flag_instruction_unit_test.sv
// self-checking bench for the bit and flag instruction unit
`timescale 1ns/1ps
module bit_flag_instruction_unit_test;
   logic        sys_clk = 1'b0;
   logic        rst     = 1'b1;
   logic        ce      = 1'b1;
   logic [3:0]  address = 4'h0;
   logic        read    = 1'b0;
   logic        write   = 1'b0;
   logic [31:0] wdata   = 32'h0000_0000;
   logic [31:0] rdata;
   logic [31:0] got;
   logic        waitreq;
   logic        sleep_req;
   logic        watchdog_restart;
   logic        brk;
   int          failures   = 0;
   int          num_checks = 0;
   int          cycles     = 0;

   bfiu_top bfiu_top_i (.SYS_CLK(sys_clk), .RST(rst), .CE(ce), .AVS_ADDRESS(address), .AVS_READ(read),
      .AVS_WRITE(write), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
      .SLEEP_REQ(sleep_req), .WATCHDOG_RESTART(watchdog_restart), .DEBUG_BREAK(brk));

   initial forever #12.5 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures = failures + 1;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      address <= a;
      wdata <= d;
      read <= !wr;
      write <= wr;
      do @(posedge sys_clk); while (waitreq !== 1'b0);
      got = rdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   // status bits: c0 z1 n2 v3 s4 h5 t6 i7
   function automatic void model(input logic [4:0] op, input logic [2:0] b, input logic [7:0] d,
                                 input logic [7:0] s, output logic [7:0] r, output logic [7:0] so);
      r = d;
      so = s;
      case (op)
         5'h01: begin r = {d[6:0], s[0]}; so[0] = d[7]; end
         5'h02: begin r = {s[0], d[7:1]}; so[0] = d[0]; end
         5'h03: begin r = {d[7], d[7:1]}; so[0] = d[0]; end
         5'h04: r = {d[3:0], d[7:4]};
         5'h05: so[6] = d[b];
         5'h06: r[b] = s[6];
         5'h07: so[3] = 1'b1;
         5'h08: so[3] = 1'b0;
         5'h09: so[4] = 1'b1;
         5'h0a: so[4] = 1'b0;
         5'h0b: so[5] = 1'b0;
         5'h0f: so[b] = 1'b1;
         5'h10: so[b] = 1'b0;
         default: ;
      endcase
      if (op inside {5'h01, 5'h02, 5'h03}) begin
         so[1] = (r == 8'h00);
         so[2] = r[7];
         so[3] = r[7] ^ so[0];
         so[4] = so[2] ^ so[3];
      end
   endfunction

   task automatic test_reset();
      bus(1'b0, bfiu_pkg::ADDR_STATUS, 32'h0000_0000);
      check(got, {24'h00_0000, bfiu_pkg::STATUS_RESET}, "status after reset");
      bus(1'b0, bfiu_pkg::ADDR_OPERAND, 32'h0000_0000);
      check(got, {24'h00_0000, bfiu_pkg::DATA_RESET}, "operand after reset");
   endtask

   task automatic test_all_ops();
      logic [7:0] pd [3] = '{8'h81, 8'h40, 8'h00};
      logic [7:0] ps [3] = '{8'h01, 8'hfe, 8'h00};
      logic [7:0] r;
      logic [7:0] so;
      logic [4:0] op;
      logic [2:0] b;
      for (int k = 0; k < 3; k++) begin
         for (int i = 0; i < 17; i++) begin
            op = i[4:0];
            b = op[2:0] ^ k[2:0];
            model(op, b, pd[k], ps[k], r, so);
            bus(1'b1, bfiu_pkg::ADDR_OPERAND, {24'h00_0000, pd[k]});
            bus(1'b1, bfiu_pkg::ADDR_STATUS, {24'h00_0000, ps[k]});
            bus(1'b1, bfiu_pkg::ADDR_COMMAND, {21'h00_0000, b, 3'h0, op});
            #1;
            check({29'h0000_0000, sleep_req, watchdog_restart, brk}, {29'h0000_0000, op == 12, op == 13, op == 14}, "pulse");
            bus(1'b0, bfiu_pkg::ADDR_RESULT, 32'h0000_0000);
            check(got, {24'h00_0000, r}, "result");
            bus(1'b0, bfiu_pkg::ADDR_STATUS, 32'h0000_0000);
            check(got, {24'h00_0000, so}, "status");
         end
      end
   endtask

   task automatic test_unmapped();
      bus(1'b1, bfiu_pkg::ADDR_STATUS, 32'h0000_005a);
      bus(1'b1, 4'h2, 32'h0000_00ff);
      bus(1'b0, 4'h2, 32'h0000_0000);
      check(got, 32'h0000_0000, "unmapped read");
      bus(1'b0, bfiu_pkg::ADDR_STATUS, 32'h0000_0000);
      check(got, 32'h0000_005a, "status after unmapped write");
      bus(1'b0, bfiu_pkg::ADDR_COMMAND, 32'h0000_0000);
      check(got, 32'h0000_0000, "command read");
   endtask

   // enable dropped while the slave already holds the command pending
   task automatic test_clock_enable();
      logic [7:0] r;
      logic [7:0] so;
      model(bfiu_pkg::OP_ROTATE_LEFT_CARRY, 3'h0, 8'h81, 8'h00, r, so);
      bus(1'b1, bfiu_pkg::ADDR_OPERAND, 32'h0000_0081);
      bus(1'b1, bfiu_pkg::ADDR_STATUS, 32'h0000_0000);
      fork
         bus(1'b1, bfiu_pkg::ADDR_COMMAND, {27'h000_0000, bfiu_pkg::OP_ROTATE_LEFT_CARRY});
         begin
            repeat (2) @(posedge sys_clk);
            ce <= 1'b0;
            repeat (3) @(posedge sys_clk);
            check({31'h0000_0000, waitreq}, 32'h0000_0001, "wait while frozen");
            ce <= 1'b1;
         end
      join
      bus(1'b0, bfiu_pkg::ADDR_RESULT, 32'h0000_0000);
      check(got, {24'h00_0000, r}, "result after freeze");
      bus(1'b0, bfiu_pkg::ADDR_STATUS, 32'h0000_0000);
      check(got, {24'h00_0000, so}, "status after freeze");
   endtask

   task automatic test_mid_reset();
      bus(1'b1, bfiu_pkg::ADDR_STATUS, 32'h0000_00ff);
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      test_reset();
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      test_reset();
      test_all_ops();
      test_unmapped();
      test_clock_enable();
      test_mid_reset();
      wrap_up();
   end
endmodule // bit_flag_instruction_unit_test
